// ==== core/sfp_policy.sv ====
// Forwarding policy engine: tail tag, IGMP trap, mirroring, rate, filter
// Contract
// RULE1: tail tag appears only on frames crossing the host port 3
// RULE2: tagging works only while the tag-enable bit 6 is set
// RULE3: tag is one byte; bits 1:0 port, bits 3:2 priority, rest unused
// RULE4: host tag bits 1:0: 00 lookup, 01 port1, 10 port2, 11 both
// RULE5: host tag bits 3:2 give frame priority 0 to 3
// RULE6: tag to host: bit 0 is 0 from port 1, 1 from port 2
// RULE7: recognised IGMP frames go only to host port 3
// RULE8: IGMP is IP, Ethernet or SNAP, version 4, protocol 2
// RULE9: host targets IGMP replies with tag bits 1:0, else broadcast; the code sends tag 00 to the lookup mask, not broadcast
// RULE10: tag byte is stripped when the reply leaves a network port
// RULE11: receive-sniff port frames also copied to sniffer; bad ones optional
// RULE12: transmit-sniff port frames also delivered to the sniffer
// RULE13: mirror-AND bit mirrors only rx-sniff in and tx-sniff out
// RULE14: several sniff sources, any sniffer; roles set per port
// RULE15: rates from 64 kbps, 64 kbps steps then 1 Mbps steps
// RULE16: ingress per priority and egress per queue limits, per port
// RULE17: at 10 Mb/s a rate above 10 Mbps means no limit
// RULE18: byte count DA to FCS, optionally plus IFG or preamble
// RULE19: ingress meters chosen classes and drops over-rate frames
// RULE20: egress leaky bucket per queue stretches the frame gap
// RULE21: exhausted queue memory causes ingress drop or flow control
// RULE22: unknown unicast is filtered or forwarded per a control bit
// RULE23: unused tag bits toward the host are driven to zero
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module sfp_policy (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fr_valid,
   input wire sfp_pkg::sfp_frame_s fr,
   input wire logic [2:0] port_speed10,
   input wire logic [2:0] qmem_full,
   output logic dec_valid,
   output sfp_pkg::sfp_dec_s dec,
   output logic [2:0] fc_pause,
   output logic [sfp_pkg::NBUCK-1:0] eg_gap_hold
);
   import sfp_pkg::*;

   logic tag_en;
   logic mir_and;
   logic mir_err;
   logic uu_filter;
   logic [5:0] port_cfg [NPORT];
   logic [2:0] rate_cfg;
   logic [NBUCK*RCW-1:0] ig_rate;
   logic [NBUCK*RCW-1:0] eg_rate;
   logic [15:0] drop_count;
   logic wr_en;
   logic [31:0] next_prdata;
   logic addr_ok;
   logic [NBUCK-1:0] ig_over;
   logic [NBUCK-1:0] ig_charge;
   logic [NBUCK-1:0] eg_charge;
   logic [NBUCK-1:0] ig_slow;
   logic [NBUCK-1:0] eg_slow;
   logic [11:0] acct;
   sfp_dec_s next_dec;
   logic next_dropped;
   logic [2:0] next_fc_set;

   function automatic logic [31:0] pack_rates(input logic [27:0] r);
      pack_rates = {1'b0, r[27:21], 1'b0, r[20:14], 1'b0, r[13:7],
                    1'b0, r[6:0]};
   endfunction : pack_rates

   function automatic logic [27:0] unpack_rates(input logic [31:0] w);
      unpack_rates = {w[30:24], w[22:16], w[14:8], w[6:0]};
   endfunction : unpack_rates

   function automatic logic [3:0] bucket(input logic [1:0] p,
                                         input logic [1:0] q);
      bucket = 4'({p, q});
   endfunction : bucket

   // APB: one wait cycle, then registered read data
   assign wr_en = psel && penable && pwrite && pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_comb begin
      addr_ok = 1'b1;
      next_prdata = 32'h00000000;
      unique case (paddr)
         ADDR_TAG: next_prdata[BIT_TAG_EN] = tag_en;
         ADDR_MIRROR: begin
            next_prdata[BIT_MIR_AND] = mir_and;
            next_prdata[BIT_MIR_ERR] = mir_err;
         end
         ADDR_UNICAST: next_prdata[BIT_UU_FILTER] = uu_filter;
         ADDR_PORT1: next_prdata[5:0] = port_cfg[PORT1];
         ADDR_PORT2: next_prdata[5:0] = port_cfg[PORT2];
         ADDR_PORT3: next_prdata[5:0] = port_cfg[PORT_HOST];
         ADDR_RATECFG: next_prdata[2:0] = rate_cfg;
         ADDR_IGRATE1: next_prdata = pack_rates(ig_rate[27:0]);
         ADDR_IGRATE2: next_prdata = pack_rates(ig_rate[55:28]);
         ADDR_IGRATE3: next_prdata = pack_rates(ig_rate[83:56]);
         ADDR_EGRATE1: next_prdata = pack_rates(eg_rate[27:0]);
         ADDR_EGRATE2: next_prdata = pack_rates(eg_rate[55:28]);
         ADDR_EGRATE3: next_prdata = pack_rates(eg_rate[83:56]);
         ADDR_STATUS: begin
            next_prdata[NBUCK-1:0] = ig_over;
            next_prdata[STATUS_EG_LO +: NBUCK] = eg_gap_hold;
         end
         ADDR_DROPS: next_prdata[15:0] = drop_count;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata <= pwrite ? 32'h00000000 : next_prdata;
         pslverr <= !addr_ok;
      end else begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tag_en <= 1'b0;
         mir_and <= 1'b0;
         mir_err <= 1'b0;
         uu_filter <= 1'b0;
         rate_cfg <= 3'h0;
         for (int i = 0; i < NPORT; i++) begin
            port_cfg[i] <= 6'h00;
         end
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_TAG: tag_en <= pwdata[BIT_TAG_EN]; // RULE2
            ADDR_MIRROR: begin
               mir_and <= pwdata[BIT_MIR_AND];
               mir_err <= pwdata[BIT_MIR_ERR];
            end
            ADDR_UNICAST: uu_filter <= pwdata[BIT_UU_FILTER];
            ADDR_PORT1: port_cfg[PORT1] <= pwdata[5:0]; // RULE14
            ADDR_PORT2: port_cfg[PORT2] <= pwdata[5:0]; // RULE14
            ADDR_PORT3: port_cfg[PORT_HOST] <= pwdata[5:0]; // RULE14
            ADDR_RATECFG: rate_cfg <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Rate code writes, four priorities per word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ig_rate <= '0;
         eg_rate <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_IGRATE1: ig_rate[27:0] <= unpack_rates(pwdata);
            ADDR_IGRATE2: ig_rate[55:28] <= unpack_rates(pwdata);
            ADDR_IGRATE3: ig_rate[83:56] <= unpack_rates(pwdata);
            ADDR_EGRATE1: eg_rate[27:0] <= unpack_rates(pwdata);
            ADDR_EGRATE2: eg_rate[55:28] <= unpack_rates(pwdata);
            ADDR_EGRATE3: eg_rate[83:56] <= unpack_rates(pwdata);
            default: ;
         endcase
      end
   end

   // Accounted frame size
   always_comb begin
      acct = {1'b0, fr.len}; // RULE18
      if (rate_cfg[BIT_INC_IFG]) begin
         acct = acct + 12'(IFG_BYTES); // RULE18
      end
      if (rate_cfg[BIT_INC_PRE]) begin
         acct = acct + 12'(PREAMBLE_BYTES); // RULE18
      end
   end

   // Forwarding decision
   always_comb begin
      logic host_in;
      logic igmp;
      logic unknown_uc;
      logic cls_hit;
      logic rx_sniff;
      logic tx_sniff;
      logic mirror;
      logic [2:0] tx_mask;
      logic [2:0] sniffer;
      logic [1:0] cls;
      host_in = 1'b0;
      igmp = 1'b0;
      unknown_uc = 1'b0;
      cls_hit = 1'b0;
      rx_sniff = 1'b0;
      tx_sniff = 1'b0;
      mirror = 1'b0;
      tx_mask = 3'h0;
      sniffer = 3'h0;
      cls = port_cfg[fr.src][BIT_CLASS_LO +: 2];
      next_dec = '0;
      next_dropped = 1'b0;
      next_fc_set = 3'h0;
      ig_charge = '0;
      eg_charge = '0;
      host_in = (fr.src == PORT_HOST) && tag_en; // RULE2
      next_dec.dst_mask = fr.lookup_mask;
      next_dec.prio = fr.prio;
      if (host_in) begin
         next_dec.strip_tag = 1'b1; // RULE10
         next_dec.prio = fr.tag[3:2]; // RULE5
         unique case (fr.tag[1:0]) // RULE4
            2'h0: next_dec.dst_mask = fr.lookup_mask;
            2'h1: next_dec.dst_mask = MASK_P1;
            2'h2: next_dec.dst_mask = MASK_P2;
            2'h3: next_dec.dst_mask = MASK_P1 | MASK_P2;
         endcase
      end
      igmp = (fr.eth_ip || fr.snap_ip) && (fr.ip_ver == IP_VER4)
             && (fr.ip_proto == IP_PROTO_IGMP); // RULE8
      unknown_uc = !fr.da_mcast && !fr.da_bcast && !fr.lookup_hit;
      if (igmp && (fr.src != PORT_HOST)) begin
         next_dec.igmp = 1'b1;
         next_dec.dst_mask = MASK_HOST; // RULE7
      end else if (unknown_uc && uu_filter &&
                   !(host_in && fr.tag[1:0] != 2'h0)) begin
         next_dec.dst_mask = 3'h0; // RULE22
      end
      // Never send a frame back to its own port
      next_dec.dst_mask[fr.src] = 1'b0;
      // Mirroring
      for (int p = 0; p < NPORT; p++) begin
         tx_mask[p] = port_cfg[p][BIT_TX_SNIFF];
         sniffer[p] = port_cfg[p][BIT_SNIFFER];
      end
      rx_sniff = port_cfg[fr.src][BIT_RX_SNIFF]; // RULE11
      tx_sniff = |(next_dec.dst_mask & tx_mask); // RULE12
      if (mir_and) begin
         mirror = rx_sniff && tx_sniff; // RULE13
      end else begin
         mirror = rx_sniff || tx_sniff; // RULE14
      end
      if (fr.rx_err) begin
         next_dec.dst_mask = 3'h0;
         mirror = rx_sniff && mir_err && !mir_and; // RULE11
      end
      if (mirror && !next_dec.igmp) begin
         next_dec.dst_mask = next_dec.dst_mask | sniffer;
         next_dec.dst_mask[fr.src] = 1'b0;
      end
      // Ingress metering on selected classes
      unique case (cls) // RULE19
         CLASS_ALL: cls_hit = 1'b1;
         CLASS_MCAST: cls_hit = fr.da_mcast && !fr.da_bcast;
         CLASS_BCAST: cls_hit = fr.da_bcast;
         CLASS_FLOOD: cls_hit = unknown_uc;
      endcase
      if (cls_hit && ig_over[bucket(fr.src, next_dec.prio)]) begin
         next_dec.dst_mask = 3'h0; // RULE19
      end
      // Queue memory exhaustion
      if (|(next_dec.dst_mask & qmem_full)) begin
         if (rate_cfg[BIT_FC_EN]) begin
            next_fc_set[fr.src] = 1'b1; // RULE21
         end
         next_dec.dst_mask = 3'h0; // RULE21
      end
      next_dec.drop = (next_dec.dst_mask == 3'h0);
      next_dropped = fr_valid && next_dec.drop;
      // Tail tag toward the host
      next_dec.add_tag = tag_en && next_dec.dst_mask[PORT_HOST]; // RULE1
      if (next_dec.add_tag) begin
         next_dec.tag_out = {TAG_UNUSED, 3'h0,
                             fr.src == PORT2}; // RULE6 RULE23 RULE3
      end
      next_dec.strip_tag = next_dec.strip_tag
                           && |next_dec.dst_mask[1:0]; // RULE1
      if (fr_valid && cls_hit && !next_dec.drop) begin
         ig_charge[bucket(fr.src, next_dec.prio)] = 1'b1; // RULE16
      end
      for (int p = 0; p < NPORT; p++) begin
         if (fr_valid && next_dec.dst_mask[p]) begin
            eg_charge[bucket(2'(p), next_dec.prio)] = 1'b1; // RULE20
         end
      end
   end

   // Decision register, answered the cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid <= 1'b0;
         dec <= '0;
      end else begin
         dec_valid <= fr_valid;
         if (fr_valid) begin
            dec <= next_dec;
         end
      end
   end

   // Pause request per ingress port; a new set wins over the release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fc_pause <= 3'h0;
      end else if (fr_valid && |next_fc_set) begin
         fc_pause <= fc_pause | next_fc_set; // RULE21
      end else if (qmem_full == 3'h0) begin
         fc_pause <= 3'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_count <= 16'h0000;
      end else if (next_dropped && drop_count != 16'hFFFF) begin
         drop_count <= drop_count + 16'h0001;
      end
   end

   always_comb begin
      for (int i = 0; i < NBUCK; i++) begin
         ig_slow[i] = port_speed10[i / NPRIO]; // RULE17
         eg_slow[i] = port_speed10[i / NPRIO];
      end
   end

   sfp_rate_bank #(
      .NB(NBUCK)
   ) u_ingress (
      .pclk(pclk),
      .presetn(presetn),
      .rate_code(ig_rate),
      .slow(ig_slow),
      .charge(ig_charge),
      .charge_bytes(acct),
      .over(ig_over)
   );

   // Egress buckets hold the next frame of a queue until credit returns
   sfp_rate_bank #(
      .NB(NBUCK)
   ) u_egress (
      .pclk(pclk),
      .presetn(presetn),
      .rate_code(eg_rate),
      .slow(eg_slow),
      .charge(eg_charge),
      .charge_bytes(acct),
      .over(eg_gap_hold) // RULE20
   );
endmodule : sfp_policy

// ==== core/sfp_rate_bank.sv ====
// Bank of token-bucket rate meters sharing one charge amount
`timescale 1ns/10ps
module sfp_rate_bank #(
   parameter int NB = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NB*sfp_pkg::RCW-1:0] rate_code,
   input wire logic [NB-1:0] slow,
   input wire logic [NB-1:0] charge,
   input wire logic [11:0] charge_bytes,
   output logic [NB-1:0] over
);
   import sfp_pkg::*;

   localparam logic signed [39:0] CAP = 40'(BURST_BYTES * UNITS_PER_BYTE);
   localparam logic [39:0] UNIT = 40'(UNITS_PER_BYTE);

   logic signed [39:0] level [NB];

   function automatic logic unlimited(input logic [RCW-1:0] c,
                                      input logic s);
      unlimited = (c == '0) || (s && (c > RATE_10M));
   endfunction : unlimited

   function automatic logic signed [39:0] step(input logic signed [39:0] l,
                                               input logic [RCW-1:0] c,
                                               input logic ch,
                                               input logic [11:0] b);
      logic signed [39:0] n;
      n = l + $signed({23'h0, sfp_rate_kbps(c)});
      if (ch) begin
         n = n - $signed({28'h0, b} * UNIT);
      end
      if (n > CAP) begin
         n = CAP;
      end
      step = n;
   endfunction : step

   // Refill each cycle at the programmed rate, charge frame bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NB; i++) begin
            level[i] <= CAP;
         end
      end else begin
         for (int i = 0; i < NB; i++) begin
            if (unlimited(rate_code[i*RCW +: RCW], slow[i])) begin
               level[i] <= CAP; // RULE17
            end else begin
               level[i] <= step(level[i], rate_code[i*RCW +: RCW],
                                charge[i], charge_bytes); // RULE15
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NB; i++) begin
         over[i] = level[i] < 0;
      end
   end
endmodule : sfp_rate_bank

// ==== inc/sfp_pkg.sv ====
// Shared constants, types and helpers of the switch forwarding policy block
package sfp_pkg;
   localparam int NPORT = 3;
   localparam int NPRIO = 4;
   localparam int NBUCK = NPORT * NPRIO;
   localparam int RCW = 7;
   // Port indices: 0 is port 1, 1 is port 2, 2 is the host port 3
   localparam logic [1:0] PORT1 = 2'h0;
   localparam logic [1:0] PORT2 = 2'h1;
   localparam logic [1:0] PORT_HOST = 2'h2;
   localparam logic [2:0] MASK_P1 = 3'h1;
   localparam logic [2:0] MASK_P2 = 3'h2;
   localparam logic [2:0] MASK_HOST = 3'h4;
   // Register byte addresses
   localparam logic [7:0] ADDR_TAG = 8'h00;
   localparam logic [7:0] ADDR_MIRROR = 8'h04;
   localparam logic [7:0] ADDR_UNICAST = 8'h08;
   localparam logic [7:0] ADDR_PORT1 = 8'h10;
   localparam logic [7:0] ADDR_PORT2 = 8'h14;
   localparam logic [7:0] ADDR_PORT3 = 8'h18;
   localparam logic [7:0] ADDR_RATECFG = 8'h1C;
   localparam logic [7:0] ADDR_IGRATE1 = 8'h20;
   localparam logic [7:0] ADDR_IGRATE2 = 8'h24;
   localparam logic [7:0] ADDR_IGRATE3 = 8'h28;
   localparam logic [7:0] ADDR_EGRATE1 = 8'h2C;
   localparam logic [7:0] ADDR_EGRATE2 = 8'h30;
   localparam logic [7:0] ADDR_EGRATE3 = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h38;
   localparam logic [7:0] ADDR_DROPS = 8'h3C;
   // Field positions
   localparam int BIT_TAG_EN = 6;
   localparam int BIT_MIR_AND = 0;
   localparam int BIT_MIR_ERR = 1;
   localparam int BIT_UU_FILTER = 0;
   localparam int BIT_RX_SNIFF = 0;
   localparam int BIT_TX_SNIFF = 1;
   localparam int BIT_SNIFFER = 2;
   localparam int BIT_CLASS_LO = 3;
   localparam int BIT_INC_IFG = 0;
   localparam int BIT_INC_PRE = 1;
   localparam int BIT_FC_EN = 2;
   localparam int STATUS_EG_LO = 16;
   // Ingress frame classes
   localparam logic [1:0] CLASS_ALL = 2'h0;
   localparam logic [1:0] CLASS_MCAST = 2'h1;
   localparam logic [1:0] CLASS_BCAST = 2'h2;
   localparam logic [1:0] CLASS_FLOOD = 2'h3;
   // IGMP recognition
   localparam logic [3:0] IP_VER4 = 4'h4;
   localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
   // Rate code: 0 no limit, 1..15 steps of 64 kbps, then 1 Mbps steps
   localparam int RATE_FINE_KBPS = 64;
   localparam int RATE_COARSE_KBPS = 1000;
   localparam logic [RCW-1:0] RATE_FINE_MAX = 7'h0F;
   localparam logic [RCW-1:0] RATE_10M = 7'h19;
   localparam int CLK_HZ = 100_000_000;
   localparam int BITS_PER_BYTE = 8;
   // Credit units: one kbps for one clock cycle
   localparam longint UNITS_PER_BYTE = longint'(CLK_HZ) * BITS_PER_BYTE / 1000;
   localparam int BURST_BYTES = 2048;
   localparam int IFG_BYTES = 12;
   localparam int PREAMBLE_BYTES = 8;
   localparam logic [3:0] TAG_UNUSED = 4'h0;

   typedef struct packed {
      logic [1:0] src;
      logic [2:0] lookup_mask;
      logic lookup_hit;
      logic da_mcast;
      logic da_bcast;
      logic eth_ip;
      logic snap_ip;
      logic [3:0] ip_ver;
      logic [7:0] ip_proto;
      logic [7:0] tag;
      logic [1:0] prio;
      logic [10:0] len;
      logic rx_err;
   } sfp_frame_s;

   typedef struct packed {
      logic [2:0] dst_mask;
      logic [1:0] prio;
      logic drop;
      logic add_tag;
      logic strip_tag;
      logic [7:0] tag_out;
      logic igmp;
   } sfp_dec_s;

   function automatic logic [16:0] sfp_rate_kbps(input logic [RCW-1:0] c);
      if (c <= RATE_FINE_MAX) begin
         sfp_rate_kbps = 17'(c * RATE_FINE_KBPS);
      end else begin
         sfp_rate_kbps = 17'((c - RATE_FINE_MAX) * RATE_COARSE_KBPS);
      end
   endfunction : sfp_rate_kbps
endpackage : sfp_pkg

// ==== test/sfp_far_side.sv ====
// Model of the network ports and host port feeding descriptors
`timescale 1ns/10ps
module sfp_far_side (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic send,
   input wire sfp_pkg::sfp_frame_s sframe,
   input wire logic [2:0] full_req,
   input wire logic [2:0] slow_req,
   output logic fr_valid,
   output sfp_pkg::sfp_frame_s fr,
   output logic [2:0] qmem_full,
   output logic [2:0] port_speed10
);
   import sfp_pkg::*;
   // Idle descriptor bus inverts its previous value every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fr_valid <= 1'b0;
         fr <= '0;
      end else begin
         fr_valid <= send;
         fr <= send ? sframe : ~fr;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qmem_full <= 3'h0;
         port_speed10 <= 3'h0;
      end else begin
         qmem_full <= full_req;
         port_speed10 <= slow_req;
      end
   end
endmodule : sfp_far_side

// ==== test/sfp_policy_properties.sv ====
// Port checker of the forwarding policy block
`timescale 1ns/10ps
module sfp_policy_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic fr_valid,
   input wire sfp_pkg::sfp_frame_s fr,
   input wire logic dec_valid,
   input wire sfp_pkg::sfp_dec_s dec
);
   import sfp_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_dec_follows: assert property (fr_valid |=> dec_valid)
      else $error("decision missing after frame");
   chk_dec_caused: assert property (dec_valid |-> $past(fr_valid))
      else $error("decision without frame");
   chk_apb_wait: assert property (psel && penable && !$past(penable)
      |-> !pready ##1 pready) else $error("apb wait state wrong");
   chk_drop_empty: assert property (dec_valid
      |-> dec.drop == (dec.dst_mask == 3'h0)) else $error("drop flag wrong");
   chk_tag_host_only: assert property (dec_valid && dec.add_tag
      |-> dec.dst_mask[2]) else $error("tag without host copy");
   chk_tag_unused: assert property (dec_valid && dec.add_tag
      |-> dec.tag_out[7:1] == 7'h00) else $error("unused tag bits set");
   chk_tag_source: assert property (dec_valid && dec.add_tag
      && $past(fr.src) != PORT_HOST
      |-> dec.tag_out[0] == ($past(fr.src) == PORT2))
      else $error("tag source bit wrong");
   chk_igmp_host: assert property (dec_valid && dec.igmp
      && $past(fr.src) != PORT_HOST |-> dec.dst_mask == MASK_HOST)
      else $error("igmp not trapped to host");
   chk_igmp_class: assert property (fr_valid && fr.src != PORT_HOST
      && (fr.eth_ip || fr.snap_ip) && fr.ip_ver == IP_VER4 && !fr.rx_err
      && fr.ip_proto == IP_PROTO_IGMP |=> dec.igmp)
      else $error("igmp not recognised");
   chk_strip_net: assert property (dec_valid && dec.strip_tag
      |-> dec.dst_mask[1:0] != 2'h0) else $error("strip without port");
   cover property (dec_valid && dec.igmp);
   cover property (dec_valid && dec.add_tag);
   cover property (dec_valid && dec.drop);
endmodule : sfp_policy_properties

bind sfp_policy sfp_policy_properties chk (.pclk, .presetn, .psel,
   .penable, .pready, .fr_valid, .fr, .dec_valid, .dec);

// ==== test/switch_forwarding_policy_bench.sv ====
// Self-checking bench of the forwarding policy block
`timescale 1ns/10ps
module switch_forwarding_policy_bench;
   import sfp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic send, fr_valid, dec_valid;
   logic [2:0] full_req, slow_req, qmem_full, port_speed10, fc_pause;
   logic [NBUCK-1:0] eg_gap_hold;
   sfp_frame_s sframe, fr, f;
   sfp_dec_s dec;
   int num_errors = 0;
   int samples_checked = 0;

   sfp_far_side far (.pclk, .presetn, .send, .sframe, .full_req,
      .slow_req, .fr_valid, .fr, .qmem_full, .port_speed10);
   sfp_policy uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .fr_valid, .fr, .port_speed10,
      .qmem_full, .dec_valid, .dec, .fc_pause, .eg_gap_hold);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         check(1'b0, "no pready");
         report_and_stop();
      end
   endtask : apb

   task automatic frame(input sfp_frame_s x);
      @(posedge pclk);
      send <= 1'b1;
      sframe <= x;
      @(posedge pclk);
      send <= 1'b0;
      @(posedge pclk);
      #1;
      check(dec_valid === 1'b1, "no decision");
   endtask : frame

   function automatic sfp_frame_s nf(input logic [1:0] s,
      input logic [2:0] m);
      nf = '0;
      nf.src = s;
      nf.lookup_mask = m;
      nf.lookup_hit = 1'b1;
      nf.len = 11'h040;
   endfunction : nf

   task automatic t_regs;
      apb(1'b0, ADDR_TAG, 32'h0);
      check(rd === 32'h0 && err === 1'b0, "tag reset");
      apb(1'b1, ADDR_TAG, 32'h40);
      apb(1'b0, ADDR_TAG, 32'h0);
      check(rd === 32'h40, "tag readback");
      apb(1'b0, 8'h40, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped");
   endtask : t_regs

   task automatic t_tag;
      for (int i = 0; i < 4; i++) begin
         f = nf(PORT_HOST, 3'h3);
         f.tag = 8'(i * 5);
         frame(f);
         check(dec.dst_mask === (i == 0 ? 3'h3 : 3'(i)), "tag dst");
         check(dec.prio === 2'(i), "tag prio");
         check(dec.strip_tag === 1'b1, "strip");
      end
      f = nf(PORT2, MASK_HOST);
      frame(f);
      check(dec.add_tag === 1'b1 && dec.tag_out === 8'h01, "p2 tag");
      f.src = PORT1;
      frame(f);
      check(dec.tag_out === 8'h00, "p1 tag");
      f = nf(PORT2, MASK_P1);
      frame(f);
      check(dec.add_tag === 1'b0, "net tag");
      apb(1'b1, ADDR_TAG, 32'h0);
      f = nf(PORT_HOST, MASK_P1);
      f.tag = 8'h02;
      frame(f);
      check(dec.dst_mask === MASK_P1 && dec.strip_tag === 1'b0, "off");
   endtask : t_tag

   task automatic t_igmp;
      for (int i = 0; i < 3; i++) begin
         f = nf(PORT1, MASK_P2);
         f.eth_ip = (i != 1);
         f.snap_ip = (i == 1);
         f.ip_ver = IP_VER4;
         f.ip_proto = (i == 2) ? 8'h03 : IP_PROTO_IGMP;
         frame(f);
         check(dec.dst_mask === (i == 2 ? MASK_P2 : MASK_HOST), "igmp");
         check(dec.igmp === (i != 2), "igmp class");
      end
   endtask : t_igmp

   task automatic t_mirror(input logic [31:0] r1, r2, r3, an,
      input logic [2:0] m, ex);
      apb(1'b1, ADDR_PORT1, r1);
      apb(1'b1, ADDR_PORT2, r2);
      apb(1'b1, ADDR_PORT3, r3);
      apb(1'b1, ADDR_MIRROR, an);
      frame(nf(PORT1, m));
      check(dec.dst_mask === ex, "mirror");
   endtask : t_mirror

   task automatic t_rate;
      f = nf(PORT1, MASK_P2);
      f.lookup_hit = 1'b0;
      apb(1'b1, ADDR_UNICAST, 32'h1);
      frame(f);
      check(dec.drop === 1'b1, "uu filter");
      apb(1'b1, ADDR_UNICAST, 32'h0);
      frame(f);
      check(dec.dst_mask === MASK_P2, "uu forward");
      apb(1'b1, ADDR_IGRATE1, 32'h1);
      f.len = 11'h5EE;
      frame(f);
      check(dec.drop === 1'b0, "in budget");
      frame(f);
      frame(f);
      check(dec.drop === 1'b1, "over rate");
      apb(1'b1, ADDR_PORT1, 32'h10);
      frame(f);
      check(dec.drop === 1'b0, "class");
      f.da_bcast = 1'b1;
      frame(f);
      check(dec.drop === 1'b1, "bcast");
      slow_req <= 3'h2;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ADDR_IGRATE2, i == 0 ? 32'h1A : 32'h19);
         f = nf(PORT2, MASK_P1);
         f.len = 11'h5EE;
         repeat (3) frame(f);
         check(dec.drop === (i == 1), "10M limit");
      end
      apb(1'b1, ADDR_EGRATE2, 32'h1);
      f.src = PORT1;
      f.lookup_mask = MASK_P2;
      repeat (2) frame(f);
      check(eg_gap_hold[4] === 1'b1, "egress hold");
      check(eg_gap_hold[5] === 1'b0, "egress queue");
      apb(1'b1, ADDR_RATECFG, 32'h4);
      full_req <= 3'h4;
      frame(nf(PORT1, MASK_HOST));
      check(dec.drop === 1'b1, "mem full");
      @(posedge pclk);
      #1;
      check(fc_pause[0] === 1'b1, "pause");
      full_req <= 3'h0;
      repeat (3) @(posedge pclk);
      #1;
      check(fc_pause === 3'h0, "pause clear");
   endtask : t_rate

   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #200000;
      num_errors++;
      $display("mismatch at %0t: watchdog", $time);
      report_and_stop();
   end

   initial begin
      {presetn, psel, penable, pwrite, send} = '0;
      {paddr, pwdata, full_req, slow_req} = '0;
      sframe = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_tag();
      t_igmp();
      t_mirror(32'h1, 32'h0, 32'h4, 32'h0, MASK_P2, 3'h6);
      t_mirror(32'h0, 32'h2, 32'h4, 32'h0, MASK_P2, 3'h6);
      t_mirror(32'h1, 32'h0, 32'h4, 32'h1, MASK_P2, 3'h2);
      t_mirror(32'h1, 32'h2, 32'h4, 32'h1, MASK_P2, 3'h6);
      t_mirror(32'h1, 32'h4, 32'h0, 32'h0, MASK_HOST, 3'h6);
      t_mirror(32'h0, 32'h0, 32'h0, 32'h0, MASK_P2, 3'h2);
      t_rate();
      report_and_stop();
   end
endmodule : switch_forwarding_policy_bench
